// ===== dpm_pkg.sv
package dpm_pkg;

	// Word layout: bit 0 sign, bits 1-8 characteristic, bits 9-35 fraction.
	localparam int FRAC_W = 27;
	localparam int CHAR_W = 8;
	localparam int WORD_W = 36;

	// Multiply loop length, octal 33.
	localparam logic [5:0] ITER_LOAD = 6'h1b;
	// Characteristic bias correction: ones at Q, P and bit 1 subtract 200 octal.
	localparam logic [9:0] BIAS_SUB = 10'h380;
	// Ones at Q, P, 1, 2, 3, 6, 8 subtract 27 decimal.
	localparam logic [9:0] LOW_CHAR_ADD = 10'h3e5;
	// Ones at Q through 8 subtract one.
	localparam logic [9:0] DEC_ONE = 10'h3ff;
	localparam logic [1:0] RST_SYNC_INIT = 2'h0;

	// One 36-bit operand word split into its fields.
	typedef struct packed {
		logic              sign;
		logic [CHAR_W-1:0] chr;
		logic [FRAC_W-1:0] frac;
	} dpm_word_t;

	// Memory request carrier.
	typedef struct packed {
		logic        req;
		logic [14:0] addr;
	} dpm_mem_req_t;

	typedef enum logic [3:0] {
		DPM_IDLE,
		DPM_ZT1,
		DPM_ZT2,
		DPM_FETCH,
		DPM_ARR1,
		DPM_MUL1,
		DPM_ARR2,
		DPM_MUL2,
		DPM_CHAR,
		DPM_SUM,
		DPM_MUL3,
		DPM_CARRY,
		DPM_NORM,
		DPM_LOWCH,
		DPM_DONE
	} dpm_state_t;

endpackage

// ===== dpm_seq.sv
// Notes on behaviour
// - Multiplicand high word from even address to storage, low word to swap.
// - Multiplier high part in accumulator, low fraction in MQ on entry.
// - MQ characteristic equals accumulator characteristic minus 27, after normalising.
// - Zero result fraction forces both characteristics to zero.
// - Product is high-high plus two cross products; low-low term never formed.
// - Zero multiplier fraction clears both fractions and ends the operation.
// - Nonzero multiplier swaps storage and MQ fractions, copies storage sign to MQ.
// - First step loads counter with octal 33, storage bits 1-8 to MQ.
// - Zero fraction in second step resets both characteristics and ends.
// - Otherwise rearrange, accept second word sign-blocked, swap, copy characteristic.
// - Accumulator sign positive when storage and MQ signs match, else negative.
// - Storage keeps its fraction, latch multiplier high from accumulator, clear accumulator.
// - Zero MQ fraction skips the first cross product.
// - First cross product by shift-and-add; only accumulator half kept.
// - Second cross product formed, characteristic computed, low bits discarded.
// - Add cross products into accumulator fraction and remember carry.
// - High-high product accumulates onto sum; remembered carry adds one.
// - Normalise only when enabled and needed, at most one position.
// - Nonzero fraction: low characteristic via adder constant into MQ bits 1-8.
// - Zero fraction: reset accumulator and MQ, copy accumulator sign to MQ.
// - Each iteration tests MQ bit 35, maybe adds, shifts right, steps counter.
// - Result characteristic is sum of characteristics less octal 200, or less 201 when normalised.
`timescale 1ns/100ps
`default_nettype none

module dpm_seq (
	input  wire logic                clk,
	input  wire logic                rst_b,
	input  wire logic                start,
	input  wire logic                norm_en,
	input  wire logic [14:0]         op_addr,
	input  wire dpm_pkg::dpm_word_t  acc_in,
	input  wire dpm_pkg::dpm_word_t  mq_in,
	input  wire dpm_pkg::dpm_word_t  mem_data,
	input  wire logic                mem_valid,
	output dpm_pkg::dpm_mem_req_t    mem_out,
	output dpm_pkg::dpm_word_t       acc_out,
	output dpm_pkg::dpm_word_t       mq_out,
	output logic                     busy,
	output logic                     done
);

	////////////////////////////////////////////////////////////////////////

	// Reset is released through two flops so its removal is synchronous.
	logic [1:0] rst_sync;
	logic       rst_n;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync <= dpm_pkg::RST_SYNC_INIT;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	////////////////////////////////////////////////////////////////////////

	// Datapath state; register names follow their machine roles.
	dpm_pkg::dpm_state_t   state, next_state;
	dpm_pkg::dpm_word_t    acc, next_acc;
	dpm_pkg::dpm_word_t    multiplier_quotient_reg, next_mq;
	dpm_pkg::dpm_word_t    stor, next_stor;
	logic [26:0]           swap, next_swap;
	logic [26:0]           latch, next_latch;
	// Keeps the high multiplier fraction for the second and third products.
	logic [26:0]           hold_c, next_hold_c;
	logic [5:0]            iteration_counter, next_cnt;
	logic                  carry9, next_carry9;
	logic                  acc_q, next_acc_q;
	logic                  acc_p, next_acc_p;
	dpm_pkg::dpm_mem_req_t mem_reg, next_mem;
	logic                  done_reg, next_done;

	// Characteristic adder is ten bits wide: Q, P overflow bits and 1-8.
	function automatic logic [9:0] char_add(input logic [9:0] a,
	                                        input logic [9:0] b);
		char_add = a + b;
	endfunction

	// One shift-and-add iteration on the 54-bit accumulator-MQ fraction.
	function automatic logic [53:0] mul_step(input logic [26:0] a,
	                                         input logic [26:0] m,
	                                         input logic [26:0] s);
		logic [27:0] sum;
		sum = {1'b0, a};
		if (m[0]) begin
			sum = sum + {1'b0, s};
		end
		mul_step = {sum, m[26:1]};
	endfunction

	logic [53:0] step_res;
	logic [27:0] frac_sum;
	logic [9:0]  chr_tmp;
	logic        frac_zero;

	// Next-value logic for the whole sequencer.
	always_comb begin
		next_state  = state;
		next_acc    = acc;
		next_mq     = multiplier_quotient_reg;
		next_stor   = stor;
		next_swap   = swap;
		next_latch  = latch;
		next_hold_c = hold_c;
		next_cnt    = iteration_counter;
		next_carry9 = carry9;
		next_acc_q  = acc_q;
		next_acc_p  = acc_p;
		next_mem    = mem_reg;
		next_done   = 1'b0;
		frac_zero   = (acc.frac == '0) && (multiplier_quotient_reg.frac == '0);
		step_res    = mul_step(acc.frac, multiplier_quotient_reg.frac, stor.frac);
		frac_sum    = {1'b0, acc.frac} + {1'b0, latch};
		chr_tmp     = '0;
		case (state)
			dpm_pkg::DPM_IDLE: begin
				if (start) begin
					next_acc   = acc_in;
					next_mq    = mq_in;
					next_acc_q = 1'b0;
					next_acc_p = 1'b0;
					// The even word is taken first.
					next_mem   = '{req: 1'b1, addr: {op_addr[14:1], 1'b0}};
					next_state = dpm_pkg::DPM_FETCH;
				end
			end
			dpm_pkg::DPM_FETCH: begin
				if (mem_valid) begin
					next_stor  = mem_data;
					next_mem   = '{req: 1'b0, addr: mem_reg.addr};
					next_state = dpm_pkg::DPM_ZT1;
				end
			end
			dpm_pkg::DPM_ZT1: begin
				if (frac_zero) begin
					next_acc.frac = '0;
					next_mq.frac  = '0;
					next_acc.chr  = '0;
					next_mq.chr   = '0;
					next_done     = 1'b1;
					next_state    = dpm_pkg::DPM_IDLE;
				end else begin
					// The high multiplicand fraction would be lost otherwise.
					next_swap      = stor.frac;
					// Both fractions move in one transfer.
					next_mq.frac   = stor.frac;
					next_stor.frac = multiplier_quotient_reg.frac;
					next_mq.sign   = stor.sign;
					next_cnt       = dpm_pkg::ITER_LOAD;
					next_mq.chr    = stor.chr;
					next_state     = dpm_pkg::DPM_ZT2;
				end
			end
			dpm_pkg::DPM_ZT2: begin
				// Tested once, before the MQ fraction is overwritten.
				if (frac_zero && !mem_reg.req) begin
					next_acc.chr = '0;
					next_mq.chr  = '0;
					next_done    = 1'b1;
					next_state   = dpm_pkg::DPM_IDLE;
				end else begin
					next_mq.frac   = stor.frac;
					next_stor.sign = acc.sign;
					// Ask for the odd word; the sequence waits here.
					next_mem       = '{req: 1'b1, addr: {mem_reg.addr[14:1], 1'b1}};
					if (mem_valid && mem_reg.req && mem_reg.addr[0]) begin
						// Sign bit blocked; word lands in swap.
						next_swap     = mem_data.frac;
						next_stor.chr = multiplier_quotient_reg.chr;
						next_stor.frac = swap;
						next_mem      = '{req: 1'b0, addr: mem_reg.addr};
						// Signs compared before MQ fraction is overwritten.
						next_acc.sign = stor.sign ^ multiplier_quotient_reg.sign;
						next_mq.frac  = stor.frac;
						next_state    = dpm_pkg::DPM_ARR1;
					end
				end
			end
			dpm_pkg::DPM_ARR1: begin
				// Accumulator fraction goes to latch and hold_c; storage keeps its own fraction.
				next_latch     = acc.frac;
				next_hold_c    = acc.frac;
				next_stor.frac = acc.frac;
				next_swap      = swap;
				next_stor.frac = stor.frac;
				next_acc.frac  = '0;
				next_cnt       = dpm_pkg::ITER_LOAD;
				if (multiplier_quotient_reg.frac == '0) begin
					next_state = dpm_pkg::DPM_ARR2;
				end else begin
					next_state = dpm_pkg::DPM_MUL1;
				end
			end
			dpm_pkg::DPM_MUL1, dpm_pkg::DPM_MUL2, dpm_pkg::DPM_MUL3: begin
				// Test bit 35, add, shift, step.
				next_acc.frac = step_res[53:27];
				next_mq.frac  = step_res[26:0];
				next_cnt      = iteration_counter - 6'h01;
				if (iteration_counter == 6'h01) begin
					if (state == dpm_pkg::DPM_MUL1) begin
						next_state = dpm_pkg::DPM_ARR2;
					end else if (state == dpm_pkg::DPM_MUL2) begin
						next_state = dpm_pkg::DPM_CHAR;
					end else begin
						next_state = dpm_pkg::DPM_CARRY;
					end
				end
			end
			dpm_pkg::DPM_ARR2: begin
				// Keep only the upper half of the first cross product.
				next_latch     = acc.frac;
				next_stor.frac = swap; // low multiplicand fraction
				next_swap      = stor.frac; // high multiplicand fraction
				next_mq.frac   = hold_c; // high multiplier fraction
				next_acc.frac  = '0;
				next_cnt       = dpm_pkg::ITER_LOAD;
				next_state     = dpm_pkg::DPM_MUL2;
			end
			dpm_pkg::DPM_CHAR: begin
				// Sum characteristics less octal 200.
				chr_tmp      = char_add({2'b00, acc.chr}, {2'b00, stor.chr});
				chr_tmp      = char_add(chr_tmp, dpm_pkg::BIAS_SUB);
				next_acc.chr = chr_tmp[7:0];
				next_acc_q   = chr_tmp[9];
				next_acc_p   = chr_tmp[8];
				next_mq.frac = '0;
				next_state   = dpm_pkg::DPM_SUM;
			end
			dpm_pkg::DPM_SUM: begin
				// Cross products summed, carry out of bit 9 kept.
				next_acc.frac  = frac_sum[26:0];
				next_carry9    = frac_sum[27];
				next_stor.frac = swap;
				next_mq.frac   = hold_c;
				next_cnt       = dpm_pkg::ITER_LOAD;
				next_state     = dpm_pkg::DPM_MUL3;
			end
			dpm_pkg::DPM_CARRY: begin
				// A remembered carry adds one to the high fraction.
				if (carry9) begin
					frac_sum = {1'b0, acc.frac} + 28'h0000001;
					if (frac_sum[27]) begin
						next_acc.frac = {1'b1, frac_sum[26:1]};
						next_mq.frac  = {frac_sum[0], multiplier_quotient_reg.frac[26:1]};
					end else begin
						next_acc.frac = frac_sum[26:0];
					end
				end
				next_state = dpm_pkg::DPM_NORM;
			end
			dpm_pkg::DPM_NORM: begin
				// Single left shift, only when enabled and needed.
				if (norm_en && !acc.frac[26] && !frac_zero) begin
					next_acc.frac = {acc.frac[25:0], multiplier_quotient_reg.frac[26]};
					next_mq.frac  = {multiplier_quotient_reg.frac[25:0], 1'b0};
					chr_tmp       = char_add({acc_q, acc_p, acc.chr}, dpm_pkg::DEC_ONE);
					next_acc.chr  = chr_tmp[7:0];
					next_acc_q    = chr_tmp[9];
					next_acc_p    = chr_tmp[8];
				end
				next_state = dpm_pkg::DPM_LOWCH;
			end
			dpm_pkg::DPM_LOWCH: begin
				if (!frac_zero) begin
					// Subtract 27 via constant add.
					chr_tmp      = char_add({acc_q, acc_p, acc.chr}, dpm_pkg::LOW_CHAR_ADD);
					next_mq.chr  = chr_tmp[7:0];
					next_mq.sign = acc.sign;
				end else begin
					next_acc.chr  = '0;
					next_acc.frac = '0;
					next_mq.chr   = '0;
					next_mq.frac  = '0;
					next_mq.sign  = acc.sign;
				end
				next_done  = 1'b1;
				next_state = dpm_pkg::DPM_IDLE;
			end
			default: begin
				next_state = dpm_pkg::DPM_IDLE;
			end
		endcase
	end

	// Registers only; everything but the busy compare is computed above.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state                   <= dpm_pkg::DPM_IDLE;
			acc                     <= '0;
			multiplier_quotient_reg <= '0;
			stor                    <= '0;
			swap                    <= '0;
			latch                   <= '0;
			hold_c                  <= '0;
			iteration_counter       <= '0;
			carry9                  <= 1'b0;
			acc_q                   <= 1'b0;
			acc_p                   <= 1'b0;
			mem_reg                 <= '0;
			done_reg                <= 1'b0;
			busy                    <= 1'b0;
		end else begin
			state                   <= next_state;
			acc                     <= next_acc;
			multiplier_quotient_reg <= next_mq;
			stor                    <= next_stor;
			swap                    <= next_swap;
			latch                   <= next_latch;
			hold_c                  <= next_hold_c;
			iteration_counter       <= next_cnt;
			carry9                  <= next_carry9;
			acc_q                   <= next_acc_q;
			acc_p                   <= next_acc_p;
			mem_reg                 <= next_mem;
			done_reg                <= next_done;
			busy                    <= (next_state != dpm_pkg::DPM_IDLE);
		end
	end

	// Outputs come straight from the flops.
	assign acc_out = acc;
	assign mq_out  = multiplier_quotient_reg;
	assign mem_out = mem_reg;
	assign done    = done_reg;

endmodule

`default_nettype wire

// ===== dpm_chk.sv
`timescale 1ns/100ps
`default_nettype none
// Pin-level watch on the multiply sequencer.
module dpm_chk (
	input wire logic                  clk,
	input wire logic                  rst_b,
	input wire logic                  start,
	input wire logic [14:0]           op_addr,
	input wire dpm_pkg::dpm_word_t    acc_in,
	input wire dpm_pkg::dpm_word_t    mem_data,
	input wire logic                  mem_valid,
	input wire dpm_pkg::dpm_mem_req_t mem_out,
	input wire dpm_pkg::dpm_word_t    acc_out,
	input wire dpm_pkg::dpm_word_t    mq_out,
	input wire logic                  busy,
	input wire logic                  done
);
	logic [14:0] even_a;
	logic        sgn_a;
	logic        sgn_m;
	logic [8:0]  bcnt;
	logic        nz;

	// A nonzero result fraction decides which ending checks apply.
	assign nz = (acc_out.frac | mq_out.frac) != '0;

	// Keep the even address, both operand signs and the busy length.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			even_a <= '0;
			sgn_a  <= 1'b0;
			sgn_m  <= 1'b0;
			bcnt   <= '0;
		end else begin
			if (mem_out.req && !mem_out.addr[0])
				even_a <= mem_out.addr;
			if (start && !busy)
				sgn_a <= acc_in.sign;
			if (mem_valid && mem_out.req && !mem_out.addr[0])
				sgn_m <= mem_data.sign;
			bcnt <= busy ? bcnt + 9'h1 : '0;
		end
	end

	////////////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	done_one_a: assert property (done |=> !done)
		else $error("done longer than one cycle");
	done_end_a: assert property (done |-> !busy && $past(busy))
		else $error("done without a busy phase");
	busy_lim_a: assert property (bcnt < 9'd300)
		else $error("operation never ends");
	even_req_a: assert property (start && !busy |-> ##[1:2]
		(mem_out.req && mem_out.addr == {op_addr[14:1], 1'b0}))
		else $error("first fetch not at the even address");
	odd_addr_a: assert property (mem_out.req && mem_out.addr[0]
		|-> mem_out.addr == (even_a | 15'h1))
		else $error("second fetch not one above the first");
	req_hold_a: assert property (mem_out.req && !mem_valid
		|=> mem_out.req && $stable(mem_out.addr))
		else $error("request dropped before the word came");
	req_drop_a: assert property (mem_out.req && mem_valid |=> !mem_out.req)
		else $error("request held after the word came");
	idle_req_a: assert property (!busy |-> !mem_out.req)
		else $error("fetch while idle");
	zero_chr_a: assert property (done && !nz
		|-> acc_out.chr == '0 && mq_out.chr == '0)
		else $error("zero result kept a characteristic");
	mq_chr_a: assert property (done && nz
		|-> mq_out.chr == acc_out.chr - 8'd27)
		else $error("low characteristic wrong");
	res_sign_a: assert property (done && nz
		|-> acc_out.sign == (sgn_a ^ sgn_m))
		else $error("result sign wrong");

	cover property (done && !nz);
	cover property (done && nz);
	cover property (mem_out.req && mem_out.addr[0] && mem_valid);
endmodule

bind dpm_seq dpm_chk chk_u (.clk(clk), .rst_b(rst_b), .start(start),
	.op_addr(op_addr), .acc_in(acc_in), .mem_data(mem_data),
	.mem_valid(mem_valid), .mem_out(mem_out), .acc_out(acc_out),
	.mq_out(mq_out), .busy(busy), .done(done));
`default_nettype wire

// ===== dpm_mem.sv
`timescale 1ns/100ps
`default_nettype none
// Memory stand-in: holds one operand pair, answers after lat cycles.
module dpm_mem (
	input  wire logic                  clk,
	input  wire dpm_pkg::dpm_mem_req_t mem_out,
	input  wire dpm_pkg::dpm_word_t    ev_w,
	input  wire dpm_pkg::dpm_word_t    od_w,
	input  wire logic [14:0]           base,
	input  wire logic [1:0]            lat,
	output dpm_pkg::dpm_word_t         mem_data,
	output logic                       mem_valid,
	output logic [7:0]                 bad_cnt
);
	logic [1:0] wait_q = 2'h0;
	logic       cool = 1'b0;

	// Quiet bus until the first request.
	initial begin
		mem_valid = 1'b0;
		mem_data = '0;
		bad_cnt = '0;
	end

	// One word per request, valid for one cycle; afterwards the lines show
	// the inverse so that a late sample never finds the old word.
	always @(posedge clk) begin
		if (mem_valid) begin
			mem_valid <= 1'b0;
			mem_data  <= ~mem_data;
			cool      <= 1'b1;
		end else if (cool) begin
			cool <= 1'b0;
		end else if (mem_out.req && wait_q != lat) begin
			wait_q <= wait_q + 2'h1;
		end else if (mem_out.req) begin
			wait_q    <= 2'h0;
			mem_valid <= 1'b1;
			mem_data  <= mem_out.addr[0] ? od_w : ev_w;
			if (mem_out.addr != (base | {14'h0, mem_out.addr[0]}))
				bad_cnt <= bad_cnt + 8'h1;
		end
	end
endmodule
`default_nettype wire

// ===== tb_double_precision_fp_multiply_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
// Random and corner multiplies against a behavioural result model.
module tb_double_precision_fp_multiply_sequencer;
	logic                  clk = 1'b0;
	logic                  rst_b, start, norm_en, mem_valid, busy, done;
	logic [14:0]           op_addr, base;
	logic [1:0]            lat;
	logic [7:0]            bad_cnt;
	dpm_pkg::dpm_word_t    acc_in, mq_in, mem_data, acc_out, mq_out, ev_w, od_w;
	dpm_pkg::dpm_mem_req_t mem_out;
	int                    n_fail = 0;
	int                    n_checks = 0;

	// Free-running 50 MHz clock.
	always #10 clk = ~clk;

	dpm_seq dut_u (.clk(clk), .rst_b(rst_b), .start(start), .norm_en(norm_en),
		.op_addr(op_addr), .acc_in(acc_in), .mq_in(mq_in), .mem_data(mem_data),
		.mem_valid(mem_valid), .mem_out(mem_out), .acc_out(acc_out),
		.mq_out(mq_out), .busy(busy), .done(done));
	dpm_mem mem_u (.clk(clk), .mem_out(mem_out), .ev_w(ev_w), .od_w(od_w),
		.base(base), .lat(lat), .mem_data(mem_data), .mem_valid(mem_valid),
		.bad_cnt(bad_cnt));

	////////////////////////////////////////
	// Count a comparison and report a mismatch at once.
	task automatic check(input logic [35:0] got, exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t %s %h/%h", $time, what, got, exp);
		end
	endtask

	task automatic final_report;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Expected {acc, mq}; the low-by-low term is left out, as the hardware
	// does, so the low fraction differs from an exact product.
	function automatic logic [71:0] ref_mul(input dpm_pkg::dpm_word_t e, o,
		a, q, input logic nrm);
		logic [54:0]        r;
		logic [27:0]        s;
		logic [7:0]         ch;
		dpm_pkg::dpm_word_t ra, rq;
		ra = '0;
		rq = '0;
		if ((a.frac | q.frac) == '0 || (a.frac | e.frac) == '0)
			return {ra, rq};
		s = 28'((55'(e.frac) * q.frac) >> 27) + 28'((55'(o.frac) * a.frac) >> 27);
		r = 55'(e.frac) * a.frac + s[26:0] + (55'(s[27]) << 27);
		ch = a.chr + e.chr - 8'h80;
		if (nrm && r != '0 && !r[53]) begin
			r = r << 1;
			ch = ch - 8'h1;
		end
		if (r == '0)
			return {ra, rq};
		ra = {a.sign ^ e.sign, ch, r[53:27]};
		rq = {1'b0, ch - 8'd27, r[26:0]};
		return {ra, rq};
	endfunction

	// Characteristics stay where sums and offsets cannot overflow.
	function automatic dpm_pkg::dpm_word_t rnd_w();
		dpm_pkg::dpm_word_t w;
		w.sign = 1'($urandom);
		w.chr = 8'(8'h60 + $urandom % 65);
		w.frac = 27'($urandom % 32'h7ffc000);
		return w;
	endfunction

	// One operation; inputs change and start is retried while busy, which
	// must be ignored. Called at a falling edge, after reset or where done was seen.
	task automatic run(input dpm_pkg::dpm_word_t e, o, a, q, input logic nrm);
		logic [71:0] exp;
		int          k;
		exp = ref_mul(e, o, a, q, nrm);
		ev_w = e;
		od_w = o;
		acc_in = a;
		mq_in = q;
		norm_en = nrm;
		op_addr = 15'($urandom);
		base = {op_addr[14:1], 1'b0};
		lat = 2'($urandom);
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		repeat (2) @(negedge clk);
		acc_in = ~a;
		mq_in = ~q;
		op_addr = ~op_addr;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 400) begin
			@(negedge clk);
			k++;
		end
		check({35'h0, done}, 36'h1, "done");
		check({1'b0, acc_out[34:0]}, {1'b0, exp[70:36]}, "acc");
		check({1'b0, mq_out[34:0]}, {1'b0, exp[34:0]}, "mq");
		if (exp[70:36] != '0)
			check({35'h0, acc_out.sign}, {35'h0, exp[71]}, "sign");
	endtask

	// Reset, then corner cases followed by random back-to-back operations.
	initial begin
		dpm_pkg::dpm_word_t e, o, a, q;
		rst_b = 1'b0;
		start = 1'b0;
		norm_en = 1'b0;
		op_addr = '0;
		base = '0;
		lat = '0;
		acc_in = '0;
		mq_in = '0;
		ev_w = '0;
		od_w = '0;
		void'($urandom(32'h0ddc3bd6));
		repeat (4) @(negedge clk);
		rst_b = 1'b1;
		repeat (3) @(negedge clk);
		for (int i = 0; i < 40; i++) begin
			e = rnd_w();
			o = rnd_w();
			a = rnd_w();
			q = rnd_w();
			case (i)
				0: {a.frac, q.frac} = '0;
				1: {a.frac, e.frac} = '0;
				2: q.frac = '0;
				3: {a.frac, e.frac, q.frac} = {27'h0, 27'h1, 27'h1};
				4: {a.frac, e.frac} = {27'h0, 27'h4000000};
				5: {e.frac, a.frac, o.frac, q.frac} = {{2{27'h7ffbfff}}, 54'h0 - 1};
				default: ;
			endcase
			run(e, o, a, q, (i == 4) ? 1'b1 : 1'($urandom));
		end
		check({28'h0, bad_cnt}, 36'h0, "addr");
		final_report();
	end

	// Cut a hang short well after the expected run length.
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		final_report();
	end
endmodule
`default_nettype wire
